// ==== test_uart_frame_error_addr_match.sv ====
`timescale 1ns/1ps
`include "uart_frame_regs.svh"

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end

module test_uart_frame_error_addr_match;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic        ack, rxd, txd, frc, capm, trig, stop_ph, seen;
  logic        t1 = 1'b0;
  logic        t2 = 1'b0;
  logic        prev_t1 = 1'b0;
  logic        pin = 1'b1;
  logic        rx_sel = 1'b0;
  logic [3:0]  cnt = 4'h0;
  logic [7:0]  rq;
  int          n;
  int          checks = 0;
  int          n_mismatch = 0;
  logic [7:0]  ridx [4] = '{`IDX_SLAVE_ADDRESS, `IDX_SLAVE_ADDR_MASK,
                            `IDX_SERIAL_CONTROL, 8'h04};
  // Control, address, mask, sent byte, ninth bit, stop bit, receive-done, spare.
  logic [35:0] rows [11] = '{36'hf0_00_00_37_e, 36'hf0_f1_fa_f0_e, 36'hf0_f1_fa_f3_c,
                             36'hf0_f1_fa_ff_e, 36'hf0_f1_fa_f0_4, 36'hf0_56_ff_57_c,
                             36'hf0_56_ff_56_e, 36'hd0_f1_fa_f3_e, 36'h70_56_ff_56_6,
                             36'h70_56_ff_56_0, 36'h70_56_ff_57_4};
  logic [10:0] t2tab [5] = '{11'h04b, 11'h00a, 11'h0cc, 11'h144, 11'h041};
  wire         rtk = rx_sel ? t2 : t1;

  uart_frame_error_addr_match uart_frame_error_addr_match_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .rxd_i(rxd), .txd_o(txd), .timer1_ovf_i(t1),
    .timer2_ovf_i(t2), .timer_ext_trigger_pin_i(pin), .t2_force_autoreload_o(frc),
    .t2_capture_mode_o(capm), .t2_trigger_o(trig));

  uart_master_model uart_master_model_inst (
    .clk_i(clk_i), .tick_i(rtk), .rxd_o(rxd), .stop_phase_o(stop_ph));

  // ****************************************************************
  // Clock and baud ticks.
  // ****************************************************************
  always #2 clk_i = ~clk_i;

  // The two tick trains never coincide, so a wrong source shows as a phase error.
  always @(posedge clk_i) begin
    cnt <= cnt + 4'h1;
    t1 <= (cnt[2:0] == 3'h7);
    t2 <= (cnt == 4'h3);
    prev_t1 <= t1;
  end

  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic timeout();
    n_mismatch++;
    $display("MISMATCH t=%0t wait ran out", $time);
    report_and_stop();
  endtask

  task automatic wb(input logic [7:0] idx, input logic wr_en, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    we <= wr_en;
    adr <= {idx, 2'b00};
    dat_w <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 40);
    if (k >= 40) begin
      timeout();
    end
    rq = dat_r[7:0];
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] idx);
    wb(idx, 1'b0, 8'h00);
  endtask

  task automatic snd(input logic [7:0] d, input logic n9, input logic b9, input logic stp);
    uart_master_model_inst.send(d, n9, b9, stp);
  endtask

  // Reads the status while the stop bit is still on the line.
  task automatic mid_read(input logic [7:0] d, input logic stp);
    int w;
    w = 0;
    fork
      snd(d, 1'b1, 1'b0, stp);
      begin
        while (stop_ph !== 1'b1 && w < 400) begin
          @(posedge clk_i);
          w++;
        end
        if (w >= 400) begin
          timeout();
        end
        rd(`IDX_SERIAL_CONTROL);
      end
    join
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ridx[i]) begin
      rd(ridx[i]);
      `CHK(rq, 8'h00)
    end
    wr(`IDX_SLAVE_ADDRESS, 8'ha5);
    wr(`IDX_SLAVE_ADDR_MASK, 8'h5a);
    rd(`IDX_SLAVE_ADDRESS);
    `CHK(rq, 8'ha5)
    rd(`IDX_SLAVE_ADDR_MASK);
    `CHK(rq, 8'h5a)
    $display("test registers finished");

    wr(`IDX_SERIAL_CONTROL, 8'hd0);
    mid_read(8'h3c, 1'b1);
    `CHK(rq[0], 1'b1)
    rd(`IDX_SERIAL_DATA);
    `CHK(rq, 8'h3c)
    wr(`IDX_POWER_CONTROL, 8'h40);
    wr(`IDX_SERIAL_CONTROL, 8'h50);
    mid_read(8'h81, 1'b1);
    `CHK(rq[0], 1'b0)
    rd(`IDX_SERIAL_CONTROL);
    `CHK(rq, 8'h51)
    mid_read(8'h81, 1'b0);
    rd(`IDX_SERIAL_CONTROL);
    `CHK(rq[7], 1'b1)
    wr(`IDX_SERIAL_CONTROL, 8'hd0);
    snd(8'h42, 1'b1, 1'b0, 1'b1);
    rd(`IDX_SERIAL_CONTROL);
    `CHK(rq, 8'hd1)
    wr(`IDX_SERIAL_CONTROL, 8'h50);
    rd(`IDX_SERIAL_CONTROL);
    `CHK(rq[7], 1'b0)
    wr(`IDX_POWER_CONTROL, 8'h00);
    rd(`IDX_SERIAL_CONTROL);
    `CHK(rq[7], 1'b1)
    snd(8'h42, 1'b1, 1'b0, 1'b0);
    wr(`IDX_POWER_CONTROL, 8'h40);
    rd(`IDX_SERIAL_CONTROL);
    `CHK(rq[7], 1'b0)
    wr(`IDX_POWER_CONTROL, 8'h00);
    $display("test framing finished");

    foreach (rows[i]) begin
      wr(`IDX_SLAVE_ADDRESS, rows[i][27:20]);
      wr(`IDX_SLAVE_ADDR_MASK, rows[i][19:12]);
      wr(`IDX_SERIAL_CONTROL, rows[i][35:28]);
      snd(rows[i][11:4], rows[i][35], rows[i][3], rows[i][2]);
      rd(`IDX_SERIAL_CONTROL);
      `CHK(rq[0], rows[i][1])
    end
    $display("test address match finished");

    foreach (t2tab[i]) begin
      wr(`IDX_TIMER2_CONTROL, t2tab[i][10:3]);
      repeat (2) @(posedge clk_i);
      `CHK({frc, capm}, t2tab[i][2:1])
      pin <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
        @(posedge clk_i);
        seen |= trig;
      end
      `CHK(seen, t2tab[i][0])
      pin <= 1'b1;
      @(posedge clk_i);
    end
    $display("test timer 2 controls finished");

    wr(`IDX_SERIAL_CONTROL, 8'hd0);
    wr(`IDX_TIMER2_CONTROL, 8'h20);
    rx_sel <= 1'b1;
    fork
      snd(8'ha6, 1'b1, 1'b1, 1'b1);
      begin
        wr(`IDX_SERIAL_DATA, 8'h3b);
        n = 0;
        do begin
          @(posedge clk_i);
          n++;
        end while (txd !== 1'b0 && n < 100);
        if (n >= 100) begin
          timeout();
        end
        `CHK(prev_t1, 1'b1)
      end
    join
    rd(`IDX_SERIAL_DATA);
    `CHK(rq, 8'ha6)
    $display("test duplex finished");
    report_and_stop();
  end
endmodule

// ==== uart_frame_error_addr_match.sv ====
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "uart_frame_regs.svh"

// How it works
// [R1] Frame check only modes 1-3, with access select
// [R2] Invalid stop bit sets the framing error flag
// [R3] Framing error cleared only by software or reset
// [R4] With frame check, receive-done at stop bit
// [R5] Address recognition follows multiprocessor enable bit
// [R6] Receive-done only when address matches given/broadcast
// [R7] Mode 1: stop bit acts as ninth bit; without frame check or recognition, ninth bit gets prior frame's stop bit
// [R8] Mode 0 ignores multiprocessor enable
// [R9] Given address: slave address under mask
// [R10] Broadcast: address OR mask, ones must match
// [R11] Address and mask registers reset to zero
// [R12] Receive baud: timer 1 or timer 2 overflow
// [R13] Transmit baud: timer 1 or timer 2 overflow
// [R14] Any serial clock select forces timer 2 reload
// [R15] Trigger edge only if enabled and not baud
// [R16] Receive and transmit run independently, separate rates
// [R17] Master sends address matching intended slaves' patterns
// [R18] Bit 7 is error flag or mode bit
// [R19] Slave address register, eight bits, resets zero
// [R20] Only address frames accepted while recognition active

module uart_frame_error_addr_match
  import uart_frame_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxd_i,
  output logic             txd_o,
  input  wire logic        timer1_ovf_i,
  input  wire logic        timer2_ovf_i,
  input  wire logic        timer_ext_trigger_pin_i,
  output logic             t2_force_autoreload_o,
  output logic             t2_capture_mode_o,
  output logic             t2_trigger_o
);

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] k);
    hit = (idx == k);
  endfunction

  // Bits that are one in care must agree between value and pattern.
  function automatic logic match(input logic [7:0] v, input logic [7:0] pat,
                                 input logic [7:0] care);
    match = (((v ^ pat) & care) == 8'h00);
  endfunction

  logic       req;
  logic       wr;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic [7:0] rd_nxt;

  assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr   = req & wb_we_i & wb_sel_i[0];
  assign idx  = wb_adr_i[9:2];
  assign wdat = wb_dat_i[7:0];

  logic wr_sc, wr_pc, wr_t2, wr_data;
  assign wr_sc   = wr & hit(idx, `IDX_SERIAL_CONTROL);
  assign wr_pc   = wr & hit(idx, `IDX_POWER_CONTROL);
  assign wr_t2   = wr & hit(idx, `IDX_TIMER2_CONTROL);
  assign wr_data = wr & hit(idx, `IDX_SERIAL_DATA);

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic       mode_b0_r, mode_b1_r, mp_en_r, rx_en_r;
  logic       tx_ninth_r, rx_ninth_r, tx_done_r, rx_done_r;
  logic       ferr_r, ferr_access_r, double_baud_r;
  logic [7:0] slave_address_r, slave_address_mask_r, rx_buf_r;
  logic       rx_sel_r, tx_sel_r, ext_en_r, cap_reload_r, ext_flag_r;
  logic       rx_accept, ferr_set, tx_done_set, trig_evt;
  rx_frame_t  frame;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_b0_r  <= 1'b0;
      mode_b1_r  <= 1'b0;
      mp_en_r    <= 1'b0;
      rx_en_r    <= 1'b0;
      tx_ninth_r <= 1'b0;
    end else if (wr_sc) begin
      if (!ferr_access_r) mode_b0_r <= wdat[`SC_BIT7]; // [R18]
      mode_b1_r  <= wdat[`SC_SM1];
      mp_en_r    <= wdat[`SC_MP_EN];
      rx_en_r    <= wdat[`SC_RX_EN];
      tx_ninth_r <= wdat[`SC_TX_NINTH];
    end
  end
  // A hardware set in the same cycle as a software clear wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ferr_r <= 1'b0;
    end else if (ferr_set) begin
      ferr_r <= 1'b1; // [R2]
    end else if (wr_sc && ferr_access_r) begin
      ferr_r <= wdat[`SC_BIT7]; // [R3] [R18]
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_done_r  <= 1'b0;
      rx_ninth_r <= 1'b0;
      rx_buf_r   <= `RST_BYTE;
    end else if (rx_accept) begin
      rx_done_r  <= 1'b1;
      rx_ninth_r <= ({mode_b0_r, mode_b1_r} == 2'b01) ? frame.stop : frame.ninth;
      rx_buf_r   <= frame.data;
    end else if (wr_sc) begin
      rx_done_r  <= wdat[`SC_RX_DONE];
      rx_ninth_r <= wdat[`SC_RX_NINTH];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_done_r <= 1'b0;
    end else if (tx_done_set) begin
      tx_done_r <= 1'b1;
    end else if (wr_sc) begin
      tx_done_r <= wdat[`SC_TX_DONE];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ferr_access_r <= 1'b0;
      double_baud_r <= 1'b0;
    end else if (wr_pc) begin
      ferr_access_r <= wdat[`PC_ERR_ACCESS];
      double_baud_r <= wdat[`PC_DOUBLE_BAUD];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slave_address_r      <= `RST_BYTE; // [R11] [R19]
      slave_address_mask_r <= `RST_BYTE; // [R11]
    end else if (wr && hit(idx, `IDX_SLAVE_ADDRESS)) begin
      slave_address_r <= wdat;
    end else if (wr && hit(idx, `IDX_SLAVE_ADDR_MASK)) begin
      slave_address_mask_r <= wdat;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sel_r     <= 1'b0;
      tx_sel_r     <= 1'b0;
      ext_en_r     <= 1'b0;
      cap_reload_r <= 1'b0;
    end else if (wr_t2) begin
      rx_sel_r     <= wdat[`T2_RX_SEL];
      tx_sel_r     <= wdat[`T2_TX_SEL];
      ext_en_r     <= wdat[`T2_EXT_EN];
      cap_reload_r <= wdat[`T2_CAP_RELOAD];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_flag_r <= 1'b0;
    end else if (trig_evt) begin
      ext_flag_r <= 1'b1;
    end else if (wr_t2) begin
      ext_flag_r <= wdat[`T2_EXT_FLAG];
    end
  end

  // ****************************************************************
  // Read path and acknowledge.
  // ****************************************************************
  always_comb begin
    rd_nxt = 8'h00;
    case (idx)
      `IDX_SERIAL_CONTROL: begin
        rd_nxt = {ferr_access_r ? ferr_r : mode_b0_r, mode_b1_r, mp_en_r, rx_en_r, // [R18]
                  tx_ninth_r, rx_ninth_r, tx_done_r, rx_done_r};
      end
      `IDX_SERIAL_DATA:     rd_nxt = rx_buf_r;
      `IDX_POWER_CONTROL:   rd_nxt = {double_baud_r, ferr_access_r, 6'h00};
      `IDX_SLAVE_ADDRESS:   rd_nxt = slave_address_r;
      `IDX_SLAVE_ADDR_MASK: rd_nxt = slave_address_mask_r;
      `IDX_TIMER2_CONTROL: begin
        rd_nxt = {1'b0, ext_flag_r, rx_sel_r, tx_sel_r, ext_en_r, 2'b00, cap_reload_r};
      end
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= {24'h00_0000, rd_nxt};
      end
    end
  end

  // ****************************************************************
  // Baud sources.
  // ****************************************************************
  logic [1:0] mode;
  logic [6:0] div_r, div_top;
  logic       div_tick_r, rx_tick, tx_tick;

  assign mode    = {mode_b0_r, mode_b1_r};
  assign div_top = double_baud_r ? `MODE2_DIV_FAST : `MODE2_DIV_SLOW;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r      <= 7'h00;
      div_tick_r <= 1'b0;
    end else begin
      div_tick_r <= (div_r == div_top - 7'h01);
      div_r      <= (div_r >= div_top - 7'h01) ? 7'h00 : div_r + 7'h01;
    end
  end

  // Outside mode 2 each direction picks its own timer, so the two can run at separate rates.
  assign rx_tick = (mode == 2'b10) ? div_tick_r
                 : (rx_sel_r ? timer2_ovf_i : timer1_ovf_i); // [R12] [R16]
  assign tx_tick = (mode == 2'b10) ? div_tick_r
                 : (tx_sel_r ? timer2_ovf_i : timer1_ovf_i); // [R13] [R16]

  // ****************************************************************
  // Receiver and frame filtering.
  // ****************************************************************
  logic rx_last, rx_stop, ferr_chk, mp_on, rx_ev, addr_bit, addr_ok;

  uart_rx_frame uart_rx_frame_inst (
    .clk_i   (clk_i),     .rst_i  (rst_i),   .enable_i (rx_en_r && (mode != 2'b00)),
    .nine_i  (mode_b0_r), .tick_i (rx_tick), .rxd_i    (rxd_i),
    .frame_o (frame),     .last_o (rx_last), .stop_o   (rx_stop)
  );

  assign ferr_chk = ferr_access_r && (mode != 2'b00); // [R1]
  assign mp_on    = mp_en_r && (mode != 2'b00); // [R5] [R8]
  assign rx_ev    = (ferr_chk || (mp_on && mode == 2'b01)) ? rx_stop : rx_last; // [R4] [R7]
  assign addr_bit = (mode == 2'b01) ? frame.stop : frame.ninth; // [R7] [R20]
  assign addr_ok  = match(frame.data, slave_address_r, slave_address_mask_r) // [R9]
                  | match(frame.data, slave_address_r | slave_address_mask_r,
                          slave_address_r | slave_address_mask_r); // [R10]
  assign rx_accept = rx_ev && (!mp_on || (addr_bit && addr_ok)); // [R6] [R20]
  assign ferr_set  = rx_stop && ferr_chk && !frame.stop; // [R2]

  // ****************************************************************
  // Transmitter.
  // ****************************************************************
  tx_state_t  tx_state_r;
  logic [9:0] tx_shift_r;
  logic [3:0] tx_count_r;

  assign tx_done_set = (tx_state_r == TX_BITS) && tx_tick
                    && (tx_count_r == (mode_b0_r ? `DATA_BITS + 4'h1 : `DATA_BITS));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= 10'h3ff;
      tx_count_r <= 4'h0;
      txd_o      <= 1'b1;
    end else begin
      case (tx_state_r)
        TX_IDLE: begin
          if (wr_data && mode != 2'b00) begin
            tx_state_r <= TX_BITS;
            tx_shift_r <= {1'b1, tx_ninth_r | ~mode_b0_r, wdat};
            tx_count_r <= 4'h0;
          end
        end
        TX_BITS: begin
          if (tx_tick) begin
            if (tx_count_r == 4'h0) begin
              txd_o <= 1'b0;
            end else begin
              txd_o      <= tx_shift_r[0];
              tx_shift_r <= {1'b1, tx_shift_r[9:1]};
            end
            tx_count_r <= tx_count_r + 4'h1;
            if (tx_done_set) begin
              tx_state_r <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (tx_tick) begin
            txd_o      <= 1'b1;
            tx_state_r <= TX_IDLE;
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Timer 2 steering.
  // ****************************************************************
  logic trig_d_r;
  logic force_rl;

  assign force_rl = rx_sel_r | tx_sel_r;
  assign trig_evt = trig_d_r && !timer_ext_trigger_pin_i && ext_en_r && !force_rl; // [R15]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_d_r              <= 1'b1;
      t2_trigger_o          <= 1'b0;
      t2_force_autoreload_o <= 1'b0;
      t2_capture_mode_o     <= 1'b0;
    end else begin
      trig_d_r              <= timer_ext_trigger_pin_i;
      t2_trigger_o          <= trig_evt;
      t2_force_autoreload_o <= force_rl; // [R14]
      t2_capture_mode_o     <= cap_reload_r && !force_rl; // [R14]
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ferr_sticky: assert property (ferr_r && !(wr_sc && ferr_access_r) |=> ferr_r) // [R3]
    else $error("framing error flag cleared without software");
  a_ferr_set: assert property (rx_stop && ferr_chk && !frame.stop |=> ferr_r) // [R2]
    else $error("invalid stop bit did not set framing error");
  a_rx_done_stop: assert property (rx_last && ferr_chk && !rx_done_r && !wr_sc // [R4]
                                   |=> !rx_done_r)
    else $error("receive done raised before stop bit");
  a_mp_reject: assert property (rx_ev && mp_on && !addr_ok && !rx_done_r && !wr_sc // [R6]
                                |=> !rx_done_r)
    else $error("unmatched address raised receive done");
  a_reset_addr: assert property (@(posedge clk_i) disable iff (1'b0) rst_i // [R11]
                                 |=> slave_address_r == 8'h00 && slave_address_mask_r == 8'h00)
    else $error("address registers not cleared by reset");
  a_force_reload: assert property (force_rl |=> t2_force_autoreload_o && !t2_capture_mode_o) // [R14]
    else $error("timer 2 not forced to reload");
  a_trigger_gate: assert property (t2_trigger_o |-> $past(ext_en_r) && !$past(force_rl)) // [R15]
    else $error("trigger passed while disabled");
  a_bit7_mux: assert property (req && !wb_we_i && hit(idx, `IDX_SERIAL_CONTROL) // [R18]
                               |=> wb_dat_o[7] == $past(ferr_access_r ? ferr_r : mode_b0_r))
    else $error("bit 7 read returned wrong source");

  c_ferr_seen: cover property (ferr_set);
  c_addr_hit: cover property (rx_accept && mp_on);
  c_trigger: cover property (t2_trigger_o);
  c_tx_done: cover property (tx_done_set);

endmodule

// ==== uart_frame_pkg.sv ====
package uart_frame_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       stop;
  } rx_frame_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_BITS = 2'b01,
    RX_STOP = 2'b10
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_BITS = 2'b01,
    TX_STOP = 2'b10
  } tx_state_t;

endpackage

// ==== uart_frame_regs.svh ====
`ifndef UART_FRAME_REGS_SVH
`define UART_FRAME_REGS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define IDX_POWER_CONTROL   8'h87
`define IDX_SERIAL_CONTROL  8'h98
`define IDX_SERIAL_DATA     8'h99
`define IDX_SLAVE_ADDRESS   8'ha9
`define IDX_SLAVE_ADDR_MASK 8'hb9
`define IDX_TIMER2_CONTROL  8'hc8

// ****************************************************************
// Field positions.
// ****************************************************************
`define SC_BIT7        7
`define SC_SM1         6
`define SC_MP_EN       5
`define SC_RX_EN       4
`define SC_TX_NINTH    3
`define SC_RX_NINTH    2
`define SC_TX_DONE     1
`define SC_RX_DONE     0
`define PC_DOUBLE_BAUD 7
`define PC_ERR_ACCESS  6
`define T2_EXT_FLAG    6
`define T2_RX_SEL      5
`define T2_TX_SEL      4
`define T2_EXT_EN      3
`define T2_CAP_RELOAD  0

// ****************************************************************
// Reset values and timing counts.
// ****************************************************************
`define RST_BYTE        8'h00
`define MODE2_DIV_SLOW  7'h40
`define MODE2_DIV_FAST  7'h20
`define DATA_BITS       4'h8

`endif

// ==== uart_master_model.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Serial master node that sends one frame per call.
// ****************************************************************
module uart_master_model (
  input  wire logic clk_i,
  input  wire logic tick_i,
  output logic      rxd_o,
  output logic      stop_phase_o
);
  initial begin
    rxd_o = 1'b1;
    stop_phase_o = 1'b0;
  end

  // Bits change two clocks after a tick, so the receiver samples each bit at the next tick, two clocks before it changes.
  task automatic next_bit(input logic b);
    @(posedge clk_i iff tick_i);
    repeat (2) @(posedge clk_i);
    rxd_o <= b;
  endtask

  // The caller picks an address byte that hits the intended slaves only.
  task automatic send(input logic [7:0] d, input logic nine, input logic b9,
                      input logic stp);
    next_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      next_bit(d[i]);
    end
    if (nine) begin
      next_bit(b9);
    end
    next_bit(stp);
    stop_phase_o <= 1'b1;
    // A low stop bit is released early so it is never taken for a new start.
    @(posedge clk_i iff tick_i);
    @(posedge clk_i);
    rxd_o <= 1'b1;
    stop_phase_o <= 1'b0;
  endtask
endmodule

// ==== uart_rx_frame.sv ====
`timescale 1ns/1ps
`include "uart_frame_regs.svh"

module uart_rx_frame
  import uart_frame_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      enable_i,
  input  wire logic      nine_i,
  input  wire logic      tick_i,
  input  wire logic      rxd_i,
  output rx_frame_t      frame_o,
  output logic           last_o,
  output logic           stop_o
);

  rx_state_t  state_r;
  logic [3:0] count_r;
  logic [8:0] shift_r;
  logic [3:0] nbits;

  assign nbits = nine_i ? `DATA_BITS + 4'h1 : `DATA_BITS;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= RX_IDLE;
      count_r <= 4'h0;
      shift_r <= 9'h000;
      last_o  <= 1'b0;
      stop_o  <= 1'b0;
      frame_o <= '0;
    end else begin
      last_o <= 1'b0;
      stop_o <= 1'b0;
      case (state_r)
        RX_IDLE: begin
          if (enable_i && tick_i && !rxd_i) begin
            state_r <= RX_BITS;
            count_r <= 4'h0;
          end
        end
        RX_BITS: begin
          if (tick_i) begin
            shift_r <= {rxd_i, shift_r[8:1]};
            count_r <= count_r + 4'h1;
            if (count_r == nbits - 4'h1) begin
              state_r       <= RX_STOP;
              last_o        <= 1'b1;
              frame_o.data  <= nine_i ? shift_r[8:1] : {rxd_i, shift_r[8:2]};
              frame_o.ninth <= nine_i ? rxd_i : 1'b0;
            end
          end
        end
        RX_STOP: begin
          if (tick_i) begin
            state_r      <= RX_IDLE;
            stop_o       <= 1'b1;
            frame_o.stop <= rxd_i;
          end
        end
        default: state_r <= RX_IDLE;
      endcase
    end
  end

endmodule
